// File: rtl/memory_map_pkg.sv
// Purpose: constants for the memory map, vector table and flash model
// Assumes: 16-bit cpu address space, byte-wide data
// Notes: register byte addresses on the bus equal the printed offsets
package memory_map_pkg;
    localparam logic [15:0] vec_timebase = 16'hffdc;
    localparam logic [15:0] vec_spi_tx = 16'hffde;
    localparam logic [15:0] vec_spi_rx = 16'hffe0;
    localparam logic [15:0] vec_adc = 16'hffe2;
    localparam logic [15:0] vec_keyboard = 16'hffe4;
    localparam logic [15:0] vec_serial_tx = 16'hffe6;
    localparam logic [15:0] vec_serial_rx = 16'hffe8;
    localparam logic [15:0] vec_serial_err = 16'hffea;
    localparam logic [15:0] vec_timer_b_ovf = 16'hffec;
    localparam logic [15:0] vec_timer_b_ch1 = 16'hffee;
    localparam logic [15:0] vec_timer_b_ch0 = 16'hfff0;
    localparam logic [15:0] vec_timer_a_ovf = 16'hfff2;
    localparam logic [15:0] vec_timer_a_ch1 = 16'hfff4;
    localparam logic [15:0] vec_timer_a_ch0 = 16'hfff6;
    localparam logic [15:0] vec_clock_monitor = 16'hfff8;
    localparam logic [15:0] vec_irq_pin = 16'hfffa;
    localparam logic [15:0] vec_software = 16'hfffc;
    localparam logic [15:0] vec_reset = 16'hfffe;
    localparam int num_vectors = 18;
    localparam logic [15:0] ram_low_start = 16'h0040;
    localparam logic [15:0] ram_low_end = 16'h00ff;
    localparam logic [15:0] ram_high_start = 16'h0100;
    localparam logic [15:0] ram_high_end = 16'h023f;
    localparam logic [15:0] sp_reset = 16'h00ff;
    localparam logic [15:0] flash_main_start = 16'hc000;
    localparam int flash_main_bytes = 15872;
    localparam int flash_vector_bytes = 36;
    localparam int flash_page_bytes = 64;
    localparam int flash_row_bytes = 32;
    localparam logic [7:0] flash_erased = 8'hff;
    localparam logic [15:0] addr_breakpoint_low = 16'hfe0a;
    localparam logic [15:0] addr_breakpoint_status = 16'hfe0b;
    localparam logic [15:0] addr_low_voltage = 16'hfe0c;
    localparam logic [15:0] addr_protect_start = 16'hff7e;
    localparam logic [15:0] addr_trim_five = 16'hff80;
    localparam logic [15:0] addr_trim_three = 16'hff81;
    localparam logic [15:0] addr_flash_control = 16'hfe08;
    localparam logic [15:0] addr_stack_pointer = 16'hfe10;
    localparam logic [15:0] addr_stack_cmd = 16'hfe14;
    localparam logic [15:0] addr_stack_status = 16'hfe18;
    localparam logic [15:0] addr_decode_query = 16'hfe1c;
    localparam logic [15:0] addr_decode_result = 16'hfe20;
    localparam logic [15:0] addr_flash_data = 16'hfe24;
    localparam int fc_program = 0;
    localparam int fc_erase = 1;
    localparam int bs_enable = 7;
    localparam int bs_active = 6;
    localparam logic [2:0] cmd_reset_sp = 3'h1;
    localparam logic [2:0] cmd_push = 3'h2;
    localparam logic [2:0] cmd_pull = 3'h3;
    localparam logic [2:0] cmd_interrupt = 3'h4;
    localparam logic [2:0] cmd_call = 3'h5;
    localparam logic [3:0] interrupt_push_bytes = 4'h5;
    localparam logic [3:0] call_push_bytes = 4'h2;
    localparam logic [1:0] region_none = 2'h0;
    localparam logic [1:0] region_ram = 2'h1;
    localparam logic [1:0] region_flash = 2'h2;
    localparam logic [1:0] region_vector = 2'h3;
    typedef enum logic [1:0] {
        flash_idle = 2'b00,
        flash_write = 2'b01,
        flash_wipe = 2'b10
    } flash_state_t;
endpackage

// File: rtl/memory_map.sv
// Purpose: memory map decoder, vector table, stack pointer, flash array
// Assumes: single AHB-Lite master, single transfers to any byte address
// Notes: every access answers in one wait-free data phase, always OKAY
// Contract
// - timebase vector at ffdc, lowest priority
// - spi transmit ffde, receive ffe0
// - adc ffe2, keyboard ffe4 above adc
// - serial transmit, receive, error ascending
// - timer b overflow, ch1, ch0 ascending
// - timer a vectors above timer b
// - clock monitor, irq, software, reset top
// - ram only 0040 to 023f
// - page zero ram directly addressable
// - sixteen-bit stack pointer, set by instruction
// - stack pointer resets to 00ff
// - interrupt entry pushes five bytes
// - upper index byte not stacked
// - subroutine call pushes two bytes
// - push decrements, pull increments stack pointer
// - flash main bytes plus vectors, protect
// - erased bit reads one, programmed zero
// - page erase sets 64 bytes erased
// - page holds two adjacent rows
// - byte-wide words, byte programming
// - protect and trims survive every reset
// - rows are 32 aligned bytes
// - program and erase never both set
`timescale 1ns/1ns
module memory_map
    import memory_map_pkg::*;
#(
    parameter int flash_bytes = 16384
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic low_voltage_detected,
    input wire logic breakpoint_hit,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic [15:0] stack_pointer,
    output logic breakpoint_enable,
    output logic [7:0] oscillator_trim_five_volt,
    output logic [7:0] oscillator_trim_three_volt
);
    // flash storage has no reset: content survives every reset
    logic [7:0] flash_mem [0:flash_bytes-1];
    logic [7:0] breakpoint_address_low;
    logic breakpoint_active;
    logic [2:0] lv_sync;
    logic low_voltage_flag;
    logic program_select;
    logic erase_select;
    logic [15:0] decode_query;
    logic [15:0] flash_addr;
    logic [7:0] flash_data;
    logic [15:0] next_sp;
    logic [15:0] sp_value;
    logic [14:0] query_pair;
    logic [8:0] flash_row;
    logic [7:0] flash_page;
    logic bp_low_write;
    logic bp_status_write;
    logic query_write;
    logic flash_data_write;
    logic flash_ctl_write;
    logic sp_write;
    logic stack_cmd_write;
    logic [7:0] flash_read;
    flash_state_t flash_state;
    logic ph_valid;
    logic ph_write;
    logic [15:0] ph_addr;
    logic is_ram;
    logic is_flash;
    logic is_vector;
    logic [4:0] vector_rank;
    logic [13:0] flash_index;
    logic ph_go;

    assign ph_go = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign stack_pointer = sp_value;
    assign oscillator_trim_five_volt = flash_mem[addr_trim_five[13:0]];
    assign oscillator_trim_three_volt = flash_mem[addr_trim_three[13:0]];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr <= 16'h0000;
        end else begin
            ph_valid <= ph_go;
            ph_write <= hwrite;
            ph_addr <= haddr[15:0];
        end
    end

    // region decode of the cpu-side query address
    always_comb begin
        is_ram = (decode_query >= ram_low_start)
            && (decode_query <= ram_high_end);
        is_vector = decode_query >= vec_timebase;
        is_flash = (decode_query >= flash_main_start)
            && (decode_query < 16'(flash_main_start + flash_main_bytes))
            || is_vector
            || decode_query == addr_protect_start;
    end

    assign query_pair = decode_query[15:1];

    // vector rank by address pair, 0 lowest priority to 17 highest
    always_comb begin
        vector_rank = 5'h00;
        if (query_pair == vec_timebase[15:1]) begin
            vector_rank = 5'h00;
        end else if (query_pair == vec_spi_tx[15:1]) begin
            vector_rank = 5'h01;
        end else if (query_pair == vec_spi_rx[15:1]) begin
            vector_rank = 5'h02;
        end else if (query_pair == vec_adc[15:1]) begin
            vector_rank = 5'h03;
        end else if (query_pair == vec_keyboard[15:1]) begin
            vector_rank = 5'h04;
        end else if (query_pair == vec_serial_tx[15:1]) begin
            vector_rank = 5'h05;
        end else if (query_pair == vec_serial_rx[15:1]) begin
            vector_rank = 5'h06;
        end else if (query_pair == vec_serial_err[15:1]) begin
            vector_rank = 5'h07;
        end else if (query_pair == vec_timer_b_ovf[15:1]) begin
            vector_rank = 5'h08;
        end else if (query_pair == vec_timer_b_ch1[15:1]) begin
            vector_rank = 5'h09;
        end else if (query_pair == vec_timer_b_ch0[15:1]) begin
            vector_rank = 5'h0a;
        end else if (query_pair == vec_timer_a_ovf[15:1]) begin
            vector_rank = 5'h0b;
        end else if (query_pair == vec_timer_a_ch1[15:1]) begin
            vector_rank = 5'h0c;
        end else if (query_pair == vec_timer_a_ch0[15:1]) begin
            vector_rank = 5'h0d;
        end else if (query_pair == vec_clock_monitor[15:1]) begin
            vector_rank = 5'h0e;
        end else if (query_pair == vec_irq_pin[15:1]) begin
            vector_rank = 5'h0f;
        end else if (query_pair == vec_software[15:1]) begin
            vector_rank = 5'h10;
        end else if (query_pair == vec_reset[15:1]) begin
            vector_rank = 5'h11;
        end
    end

    logic [1:0] region;
    always_comb begin
        if (is_ram) begin
            region = region_ram;
        end else if (is_vector) begin
            region = region_vector;
        end else if (is_flash) begin
            region = region_flash;
        end else begin
            region = region_none;
        end
    end

    // one write strobe per register, in the data phase of a write
    always_comb begin
        bp_low_write = 1'b0;
        bp_status_write = 1'b0;
        query_write = 1'b0;
        flash_data_write = 1'b0;
        flash_ctl_write = 1'b0;
        sp_write = 1'b0;
        stack_cmd_write = 1'b0;
        if (ph_valid && ph_write) begin
            if (ph_addr == addr_breakpoint_low) begin
                bp_low_write = 1'b1;
            end else if (ph_addr == addr_breakpoint_status) begin
                bp_status_write = 1'b1;
            end else if (ph_addr == addr_decode_query) begin
                query_write = 1'b1;
            end else if (ph_addr == addr_flash_data) begin
                flash_data_write = 1'b1;
            end else if (ph_addr == addr_flash_control) begin
                flash_ctl_write = 1'b1;
            end else if (ph_addr == addr_stack_pointer) begin
                sp_write = 1'b1;
            end else if (ph_addr == addr_stack_cmd) begin
                stack_cmd_write = 1'b1;
            end
        end
    end

    // stack pointer: full 16-bit, decrement on push, increment on pull
    always_comb begin
        next_sp = sp_value;
        if (sp_write) begin
            next_sp = hwdata[15:0];
        end else if (stack_cmd_write) begin
            case (hwdata[2:0])
                cmd_reset_sp: next_sp = sp_reset;
                cmd_push: next_sp = sp_value - 16'h0001;
                cmd_pull: next_sp = sp_value + 16'h0001;
                // index high byte excluded, so five not six
                cmd_interrupt: next_sp = sp_value
                    - 16'(interrupt_push_bytes);
                cmd_call: next_sp = sp_value - 16'(call_push_bytes);
                default: next_sp = sp_value;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sp_value <= sp_reset;
        end else begin
            sp_value <= next_sp;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            breakpoint_address_low <= 8'h00;
        end else if (bp_low_write) begin
            breakpoint_address_low <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            breakpoint_enable <= 1'b0;
        end else if (bp_status_write) begin
            breakpoint_enable <= hwdata[bs_enable];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            decode_query <= 16'h0000;
        end else if (query_write) begin
            decode_query <= hwdata[15:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flash_addr <= 16'h0000;
            flash_data <= 8'h00;
        end else if (flash_data_write) begin
            flash_addr <= hwdata[15:0];
            flash_data <= hwdata[23:16];
        end
    end

    // breakpoint active: hardware set wins, software write of 0 clears
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            breakpoint_active <= 1'b0;
        end else if (breakpoint_hit && breakpoint_enable) begin
            breakpoint_active <= 1'b1;
        end else if (bp_status_write && !hwdata[bs_active]) begin
            breakpoint_active <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lv_sync <= 3'h0;
            low_voltage_flag <= 1'b0;
        end else begin
            lv_sync <= {lv_sync[1:0], low_voltage_detected};
            if (lv_sync[1] == lv_sync[2]) begin
                low_voltage_flag <= lv_sync[2];
            end
        end
    end

    // flash control: program and erase interlocked
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            program_select <= 1'b0;
            erase_select <= 1'b0;
        end else if (flash_ctl_write) begin
            if (hwdata[fc_program] && hwdata[fc_erase]) begin
                program_select <= program_select;
                erase_select <= erase_select;
            end else begin
                program_select <= hwdata[fc_program] && !erase_select;
                erase_select <= hwdata[fc_erase] && !program_select;
            end
        end
    end

    assign flash_index = flash_addr[13:0];
    // a row is 32 bytes, a page two rows
    assign flash_row = flash_index[13:5];
    assign flash_page = flash_row[8:1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flash_state <= flash_idle;
        end else begin
            case (flash_state)
                flash_idle: begin
                    if (flash_data_write) begin
                        if (program_select) begin
                            flash_state <= flash_write;
                        end else if (erase_select) begin
                            flash_state <= flash_wipe;
                        end
                    end
                end
                default: flash_state <= flash_idle;
            endcase
        end
    end

    // array update; rows of 32 nest two to a 64-byte page
    always_ff @(posedge hclk) begin
        case (flash_state)
            flash_write: begin
                // programming only clears bits
                flash_mem[{flash_row, flash_index[4:0]}]
                    <= flash_mem[flash_index] & flash_data;
            end
            flash_wipe: begin
                for (int i = 0; i < flash_page_bytes; i++) begin
                    flash_mem[{flash_page, 6'(i)}]
                        <= flash_erased;
                end
            end
            default: begin
            end
        endcase
    end

    assign flash_read = flash_mem[flash_index];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ph_go && !hwrite) begin
            if (haddr[15:0] == addr_breakpoint_low) begin
                hrdata <= {24'h000000, breakpoint_address_low};
            end else if (haddr[15:0] == addr_breakpoint_status) begin
                hrdata <= {24'h000000, breakpoint_enable,
                    breakpoint_active, 6'h00};
            end else if (haddr[15:0] == addr_low_voltage) begin
                hrdata <= {24'h000000, low_voltage_flag, 7'h00};
            end else if (haddr[15:0] == addr_protect_start) begin
                hrdata <= {24'h000000, flash_mem[addr_protect_start[13:0]]};
            end else if (haddr[15:0] == addr_trim_five) begin
                hrdata <= {24'h000000, oscillator_trim_five_volt};
            end else if (haddr[15:0] == addr_trim_three) begin
                hrdata <= {24'h000000, oscillator_trim_three_volt};
            end else if (haddr[15:0] == addr_flash_control) begin
                hrdata <= {30'h0, erase_select, program_select};
            end else if (haddr[15:0] == addr_stack_pointer) begin
                hrdata <= {16'h0000, sp_value};
            end else if (haddr[15:0] == addr_decode_query) begin
                hrdata <= {16'h0000, decode_query};
            end else if (haddr[15:0] == addr_decode_result) begin
                hrdata <= {24'h000000, vector_rank, is_vector, region};
            end else if (haddr[15:0] == addr_flash_data) begin
                hrdata <= {8'h00, flash_read, flash_addr};
            end else begin
                hrdata <= 32'h0000_0000;
            end
        end
    end
endmodule

// File: testbench/memory_map_chk.sv
// Purpose: port assertions for the memory map block
// Assumes: one clock, async active-low reset
// Notes: bound to every memory_map instance
`timescale 1ns/1ns
module memory_map_chk
    import memory_map_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [15:0] stack_pointer,
    input wire logic [7:0] oscillator_trim_five_volt
);
    logic tk_q;
    logic [15:0] a_q;
    logic [15:0] sp_q;
    // write address phase taken, seen during its data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tk_q <= 1'b0;
            a_q <= 16'h0000;
            sp_q <= sp_reset;
        end else begin
            tk_q <= hsel && hready && htrans[1] && hwrite;
            a_q <= haddr[15:0];
            sp_q <= stack_pointer;
        end
    end
    wire logic k = tk_q && a_q == addr_stack_cmd;
    wire logic sw = tk_q && a_q == addr_stack_pointer;
    wire logic fw = tk_q && a_q == addr_flash_data;
    wire logic [2:0] o = hwdata[2:0];
    wire logic [15:0] sp = stack_pointer;
    wire logic [15:0] drop = sp_q - stack_pointer;
    wire logic [7:0] t5 = oscillator_trim_five_volt;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_init; $rose(hresetn) |-> sp == sp_reset; endproperty
    property p_push; k && o == cmd_push |=> drop == 16'h0001; endproperty
    property p_pull; k && o == cmd_pull |=> drop == 16'hffff; endproperty
    property p_irq; k && o == cmd_interrupt |=> drop == 16'h0005; endproperty
    property p_call; k && o == cmd_call |=> drop == 16'h0002; endproperty
    property p_rsp; k && o == cmd_reset_sp |=> sp == sp_reset; endproperty
    property p_spw; sw |=> sp == $past(hwdata[15:0]); endproperty
    property p_trim; $changed(t5) |-> $past(fw, 2); endproperty
    a_init: assert property (p_init) else $error("sp reset value");
    a_push: assert property (p_push) else $error("push step");
    a_pull: assert property (p_pull) else $error("pull step");
    a_irq: assert property (p_irq) else $error("irq stacking");
    a_call: assert property (p_call) else $error("call stacking");
    a_rsp: assert property (p_rsp) else $error("stack reset cmd");
    a_spw: assert property (p_spw) else $error("sp write");
    a_trim: assert property (p_trim) else $error("trim changed");
    c_irq: cover property (k && o == cmd_interrupt);
    c_call: cover property (k && o == cmd_call);
    c_trim: cover property (fw);
endmodule
bind memory_map memory_map_chk memory_map_chk_i (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hready, .hwdata, .stack_pointer,
    .oscillator_trim_five_volt);

// File: testbench/cpu_bus_model.sv
// Purpose: cpu side bus master issuing single word transfers
// Assumes: one slave whose hreadyout is the bus ready
// Notes: gap adds idle cycles before each transfer
`timescale 1ns/1ns
module cpu_bus_model (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    int gap = 0;
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    task automatic wait_ready;
        for (int n = 0; n < 64; n++) begin
            @(posedge hclk);
            if (hready === 1'b1) return;
        end
        tb_memory_map.fails++;
        tb_memory_map.final_report();
    endtask
    task automatic xfer(input logic w, input logic [15:0] a,
            input logic [31:0] d, output logic [31:0] q);
        repeat (gap + 1) @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {16'h0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        if (w) hwdata <= d;
        wait_ready();
        q = hrdata;
        // released write data must not look valid
        if (w) hwdata <= ~d;
    endtask
endmodule

// File: testbench/tb_memory_map.sv
// Purpose: self-checking bench for the memory map block
// Assumes: 125 MHz bus clock, bus tasks live in the cpu model
// Notes: flash pages are erased before use, contents start unknown
`timescale 1ns/1ns
`define chk(n, e, g) \
    begin \
        total_checks++; \
        if ((g) !== (e)) begin \
            fails++; \
            $display("unexpected %s expected %h seen %h", n, e, g); \
        end \
    end
module tb_memory_map;
    import memory_map_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic low_voltage_detected = 1'b0;
    logic breakpoint_hit = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, breakpoint_enable;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, q, e;
    logic [15:0] stack_pointer, va;
    logic [7:0] trim5, trim3;
    int fails = 0;
    int total_checks = 0;
    logic [15:0] ram_a [7] = '{16'h003f, 16'h0040, 16'h00ff, 16'h0100,
        16'h023f, 16'h0240, 16'hc000};
    logic [31:0] ram_e [7] = '{32'h0, 32'h1, 32'h1, 32'h1, 32'h1, 32'h0,
        32'h2};
    logic [2:0] op_c [5] = '{cmd_push, cmd_pull, cmd_interrupt, cmd_call,
        cmd_reset_sp};
    logic [15:0] op_e [5] = '{16'h1233, 16'h1234, 16'h122f, 16'h122d,
        16'h00ff};
    memory_map memory_map_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .low_voltage_detected,
        .breakpoint_hit, .hreadyout, .hresp, .hrdata, .stack_pointer,
        .breakpoint_enable, .oscillator_trim_five_volt(trim5),
        .oscillator_trim_three_volt(trim3));
    cpu_bus_model cpu_bus_model_i (.hclk, .hready(hreadyout), .hrdata,
        .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
    initial begin
        forever #4 hclk = ~hclk;
    end
    task automatic pulse_reset;
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        cpu_bus_model_i.xfer(1'b1, a, d, q);
        #1;
    endtask
    task automatic rc(input logic [15:0] a, input logic [31:0] x,
            input string n, input logic [31:0] m = 32'hffffffff);
        cpu_bus_model_i.xfer(1'b0, a, 32'h0, q);
        `chk(n, x, q & m)
        `chk("hresp", 1'b0, hresp)
    endtask
    task automatic dq(input logic [15:0] a, input logic [31:0] x,
            input logic [31:0] m);
        wr(addr_decode_query, {16'h0000, a});
        rc(addr_decode_result, x, "decode", m);
    endtask
    task automatic fop(input logic [31:0] c, input logic [7:0] d,
            input logic [15:0] a);
        wr(addr_flash_control, 32'h0); // a set select blocks the other
        wr(addr_flash_control, c);
        wr(addr_flash_data, {8'h00, d, a});
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        pulse_reset();
        `chk("sp port", sp_reset, stack_pointer)
        rc(addr_stack_pointer, 32'h00ff, "sp reg");
        rc(addr_breakpoint_status, 32'h0, "break status");
        rc(addr_stack_status, 32'h0, "unmapped");
        $display("test reset done");
        for (int i = 0; i < 18; i++) begin
            va = 16'hffdc + 16'(2 * i + i % 2);
            e = 32'(i * 8 + 7);
            dq(va, e, 32'hffffffff);
        end
        foreach (ram_a[j]) dq(ram_a[j], ram_e[j], 32'h7);
        $display("test decode done");
        wr(addr_stack_pointer, 32'h1234);
        `chk("sp write", 16'h1234, stack_pointer)
        foreach (op_c[j]) begin
            wr(addr_stack_cmd, {29'h0, op_c[j]});
            `chk("sp step", op_e[j], stack_pointer)
        end
        wr(addr_stack_pointer, 32'h0);
        wr(addr_stack_cmd, {29'h0, cmd_push});
        rc(addr_stack_pointer, 32'hffff, "sp wrap");
        $display("test stack done");
        cpu_bus_model_i.gap = 2;
        wr(addr_flash_control, 32'h1);
        wr(addr_flash_control, 32'h3);
        rc(addr_flash_control, 32'h1, "interlock");
        fop(32'h2, 8'h00, 16'hc010);
        fop(32'h0, 8'h00, 16'hc03f);
        rc(addr_flash_data, 32'h00ffc03f, "erased", 32'hffffff);
        fop(32'h1, 8'ha5, 16'hc020);
        fop(32'h1, 8'h0f, 16'hc020);
        fop(32'h2, 8'h00, 16'hc040);
        fop(32'h0, 8'h00, 16'hc020);
        rc(addr_flash_data, 32'h0005c020, "prog", 32'hffffff);
        fop(32'h2, 8'h00, 16'hff80);
        fop(32'h1, 8'h5a, 16'hff80);
        fop(32'h1, 8'hc3, 16'hff81);
        wr(addr_flash_control, 32'h0);
        pulse_reset();
        `chk("trim five", 8'h5a, trim5)
        `chk("trim three", 8'hc3, trim3)
        rc(addr_trim_five, 32'h5a, "trim bus");
        $display("test flash done");
        cpu_bus_model_i.gap = 0;
        wr(addr_breakpoint_status, 32'h80);
        `chk("break enable", 1'b1, breakpoint_enable)
        @(posedge hclk);
        breakpoint_hit <= 1'b1;
        @(posedge hclk);
        breakpoint_hit <= 1'b0;
        rc(addr_breakpoint_status, 32'hc0, "break hit");
        wr(addr_breakpoint_status, 32'h80);
        rc(addr_breakpoint_status, 32'h80, "break clear");
        wr(addr_breakpoint_low, 32'h5c);
        rc(addr_breakpoint_low, 32'h5c, "break low");
        @(posedge hclk);
        low_voltage_detected <= 1'b1;
        repeat (4) @(posedge hclk);
        rc(addr_low_voltage, 32'h80, "low voltage");
        $display("test status done");
        final_report();
    end
endmodule
